// ===== hdl/spd_slave.v
// two-wire slave holding presence-detect content: 256-byte array,
// protection register, page buffer and self-timed programming.
// assumes an open-drain bus with pull-up outside; pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "spd_consts.vh"

module spd_slave #(
  parameter [7:0]  ROW_COUNT      = `ROW_COUNT_DEFAULT,
  parameter [7:0]  COL_COUNT      = `COL_COUNT_DEFAULT,
  parameter [7:0]  REFRESH_TYPE   = `REFRESH_TYPE_DEFAULT,
  parameter [17:0] PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
  // core clock and reset
  input  wire CLK,
  input  wire RST_N,
  // serial bus
  input  wire SCL,
  input  wire SDA_IN,
  output reg  SDA_OUT,
  output reg  SDA_OE,
  // straps and write control
  input  wire STRAP_SELECT_BIT_HIGH,
  input  wire STRAP_SELECT_BIT_MID,
  input  wire STRAP_SELECT_BIT_LOW,
  input  wire WRITE_CONTROL_INPUT
);

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DEV   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_READ  = 3'h4;
  localparam [2:0] ST_WAIT  = 3'h5;

  // ==========================================================
  // storage
  reg  [7:0]  mem [0:255];
  reg  [7:0]  pbuf [0:15];
  reg  [7:0]  prot_reg;

  // ==========================================================
  // control state
  reg  [2:0]  state;
  reg  [3:0]  bitcnt;
  reg  [7:0]  shreg;
  reg  [7:0]  addr;
  reg         rw;
  reg         prot_sel;
  reg         host_ack;
  reg  [15:0] wmask;
  reg  [3:0]  page;
  reg         prot_pend;
  reg  [7:0]  prot_data;
  reg         prog_start;
  reg         committing;
  reg  [3:0]  cidx;
  reg         scl_q;
  reg         sda_q;

  // ==========================================================
  // conditioned inputs and program-timer busy
  wire [5:0]  clean;
  wire        scl;
  wire        sda;
  wire [2:0]  strap;
  wire        wc_low;
  wire        busy;

  input_filter #(
    .WIDTH (6)
  ) u_filter (
    .clk   (CLK),
    .rst_n (RST_N),
    .raw   ({SCL, SDA_IN, STRAP_SELECT_BIT_HIGH, STRAP_SELECT_BIT_MID,
             STRAP_SELECT_BIT_LOW, WRITE_CONTROL_INPUT}),
    .clean (clean)
  );

  assign scl    = clean[5];
  assign sda    = clean[4];
  assign strap  = clean[3:1];
  assign wc_low = ~clean[0];

  program_timer #(
    .CYCLES (PROGRAM_CYCLES)
  ) u_timer (
    .clk   (CLK),
    .rst_n (RST_N),
    .start (prog_start),
    .busy  (busy)
  );

  // ==========================================================
  // bus events
  wire scl_rise   = scl & ~scl_q;
  wire scl_fall   = ~scl & scl_q;
  wire start_cond = scl & scl_q & sda_q & ~sda;
  wire stop_cond  = scl & scl_q & ~sda_q & sda;
  wire in_program = busy | committing | prog_start;

  wire sel_array   = (shreg[7:4] == `SEL_ARRAY);
  wire sel_protect = (shreg[7:4] == `SEL_PROTECT);
  wire sel_match   = (sel_array | sel_protect) & (shreg[3:1] == strap);

  wire [7:0] rd_byte = prot_sel ? prot_reg : mem[addr];

  // ==========================================================
  // stored content
  integer k;
  initial begin
    for (k = 0; k < 256; k = k + 1) begin
      mem[k] = 8'h00;
    end
    mem[`OFS_USED_BYTE_COUNT]      = `RST_USED_BYTE_COUNT;
    mem[`OFS_TOTAL_STORE_SIZE]     = `RST_TOTAL_STORE_SIZE;
    mem[`OFS_MEMORY_TYPE_CODE]     = `RST_MEMORY_TYPE_CODE;
    mem[`OFS_ROW_ADDRESS_COUNT]    = ROW_COUNT;
    mem[`OFS_COLUMN_ADDRESS_COUNT] = COL_COUNT;
    mem[`OFS_PHYSICAL_RANK_COUNT]  = `RST_PHYSICAL_RANK_COUNT;
    mem[`OFS_DATA_WIDTH_LOW]       = `RST_DATA_WIDTH_LOW;
    mem[`OFS_DATA_WIDTH_HIGH]      = `RST_DATA_WIDTH_HIGH;
    mem[`OFS_VOLTAGE_LEVEL]        = `RST_VOLTAGE_LEVEL;
    mem[`OFS_CYCLE_TIME_TOP]       = `RST_CYCLE_TIME_TOP;
    mem[`OFS_ACCESS_TIME_TOP]      = `RST_ACCESS_TIME_TOP;
    mem[`OFS_MODULE_CONFIG_TYPE]   = `RST_MODULE_CONFIG_TYPE;
    mem[`OFS_REFRESH_RATE_TYPE]    = REFRESH_TYPE;
    mem[`OFS_PRIMARY_WIDTH]        = `RST_PRIMARY_WIDTH;
    mem[`OFS_CHECK_WIDTH]          = `RST_CHECK_WIDTH;
    mem[`OFS_COLUMN_MIN_DELAY]     = `RST_COLUMN_MIN_DELAY;
    mem[`OFS_BURST_LENGTHS]        = `RST_BURST_LENGTHS;
    prot_reg = 8'h00;
  end

  // ==========================================================
  // program cycle: page buffer copied into the array
  always @(posedge CLK) begin
    if (committing && wmask[cidx]) begin
      mem[{page, cidx}] <= pbuf[cidx];
    end
    if (committing && (cidx == 4'h0) && prot_pend) begin
      prot_reg <= prot_data;
    end
  end

  // ==========================================================
  // serial protocol engine
  always @(posedge CLK) begin
    if (!RST_N) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      addr       <= 8'h00;
      rw         <= 1'b0;
      prot_sel   <= 1'b0;
      host_ack   <= 1'b0;
      wmask      <= 16'h0000;
      page       <= 4'h0;
      prot_pend  <= 1'b0;
      prot_data  <= 8'h00;
      prog_start <= 1'b0;
      committing <= 1'b0;
      cidx       <= 4'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      SDA_OUT    <= 1'b0;
      SDA_OE     <= 1'b0;
    end else begin
      scl_q      <= scl;
      sda_q      <= sda;
      SDA_OUT    <= 1'b0;
      prog_start <= 1'b0;

      // walk the page buffer once per program cycle
      if (committing) begin
        if (cidx == 4'hf) begin
          committing <= 1'b0;
          wmask      <= 16'h0000;
          prot_pend  <= 1'b0;
        end else begin
          cidx <= cidx + 4'h1;
        end
      end

      if (start_cond) begin
        SDA_OE <= 1'b0;
        // outside a program cycle, the clock fall that closes the start wraps this to zero
        bitcnt <= 4'hf;
        if (in_program) begin
          state <= ST_IDLE;
        end else begin
          state     <= ST_DEV;
          wmask     <= 16'h0000;
          prot_pend <= 1'b0;
        end
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        SDA_OE <= 1'b0;
        if (((|wmask) | prot_pend) && !in_program && (state == ST_WDATA)) begin
          prog_start <= 1'b1;
          committing <= 1'b1;
          cidx       <= 4'h0;
        end
      end else if (scl_rise) begin
        if (bitcnt == 4'h8) begin
          host_ack <= ~sda;
        end else if (state != ST_READ) begin
          shreg <= {shreg[6:0], sda};
        end
      end else if (scl_fall) begin
        case (state)
          ST_DEV: begin
            if (bitcnt == 4'h7) begin
              if (sel_match) begin
                SDA_OE   <= 1'b1;
                bitcnt   <= 4'h8;
                rw       <= shreg[0];
                prot_sel <= sel_protect;
              end else begin
                state <= ST_WAIT;
              end
            end else if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (rw) begin
                state  <= ST_READ;
                shreg  <= rd_byte;
                SDA_OE <= ~rd_byte[7];
              end else begin
                state  <= ST_ADDR;
                SDA_OE <= 1'b0;
              end
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          ST_ADDR: begin
            if (bitcnt == 4'h7) begin
              addr   <= shreg;
              page   <= shreg[7:4];
              SDA_OE <= 1'b1;
              bitcnt <= 4'h8;
            end else if (bitcnt == 4'h8) begin
              state  <= ST_WDATA;
              SDA_OE <= 1'b0;
              bitcnt <= 4'h0;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          ST_WDATA: begin
            if (bitcnt == 4'h7) begin
              SDA_OE <= 1'b1;
              bitcnt <= 4'h8;
              addr   <= {addr[7:4], addr[3:0] + 4'h1};
              if (wc_low) begin
                if (prot_sel) begin
                  prot_pend <= 1'b1;
                  prot_data <= shreg;
                end else begin
                  pbuf[addr[3:0]]  <= shreg;
                  wmask[addr[3:0]] <= 1'b1;
                end
              end
            end else if (bitcnt == 4'h8) begin
              SDA_OE <= 1'b0;
              bitcnt <= 4'h0;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          ST_READ: begin
            if (bitcnt < 4'h7) begin
              shreg  <= {shreg[6:0], 1'b0};
              SDA_OE <= ~shreg[6];
              bitcnt <= bitcnt + 4'h1;
            end else if (bitcnt == 4'h7) begin
              SDA_OE <= 1'b0;
              bitcnt <= 4'h8;
              addr   <= addr + 8'h01;
            end else if (host_ack) begin
              shreg  <= rd_byte;
              SDA_OE <= ~rd_byte[7];
              bitcnt <= 4'h0;
            end else begin
              state  <= ST_WAIT;
              SDA_OE <= 1'b0;
            end
          end
          ST_WAIT: begin
            SDA_OE <= 1'b0;
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // spd_slave
`default_nettype wire

// ===== shared/spd_consts.vh
// constants for the presence-detect serial store: select codes,
// content offsets, content values and timing counts.
// assumes a 25 MHz core clock and a serial clock made by the host.
`ifndef SPD_CONSTS_VH
`define SPD_CONSTS_VH

// ==========================================================
// select codes
`define SEL_ARRAY                4'ha
`define SEL_PROTECT              4'h6

// ==========================================================
// content offsets
`define OFS_USED_BYTE_COUNT      8'h00
`define OFS_TOTAL_STORE_SIZE     8'h01
`define OFS_MEMORY_TYPE_CODE     8'h02
`define OFS_ROW_ADDRESS_COUNT    8'h03
`define OFS_COLUMN_ADDRESS_COUNT 8'h04
`define OFS_PHYSICAL_RANK_COUNT  8'h05
`define OFS_DATA_WIDTH_LOW       8'h06
`define OFS_DATA_WIDTH_HIGH      8'h07
`define OFS_VOLTAGE_LEVEL        8'h08
`define OFS_CYCLE_TIME_TOP       8'h09
`define OFS_ACCESS_TIME_TOP      8'h0a
`define OFS_MODULE_CONFIG_TYPE   8'h0b
`define OFS_REFRESH_RATE_TYPE    8'h0c
`define OFS_PRIMARY_WIDTH        8'h0d
`define OFS_CHECK_WIDTH          8'h0e
`define OFS_COLUMN_MIN_DELAY     8'h0f
`define OFS_BURST_LENGTHS        8'h10

// ==========================================================
// content values
`define RST_USED_BYTE_COUNT      8'h80
`define RST_TOTAL_STORE_SIZE     8'h08
`define RST_MEMORY_TYPE_CODE     8'h07
`define ROW_COUNT_DEFAULT        8'h0d
`define COL_COUNT_DEFAULT        8'h0a
`define RST_PHYSICAL_RANK_COUNT  8'h01
`define RST_DATA_WIDTH_LOW       8'h48
`define RST_DATA_WIDTH_HIGH      8'h00
`define RST_VOLTAGE_LEVEL        8'h04
`define RST_CYCLE_TIME_TOP       8'h50
`define RST_ACCESS_TIME_TOP      8'h70
`define RST_MODULE_CONFIG_TYPE   8'h02
`define REFRESH_TYPE_DEFAULT     8'h82
`define RST_PRIMARY_WIDTH        8'h08
`define RST_CHECK_WIDTH          8'h08
`define RST_COLUMN_MIN_DELAY     8'h01
`define RST_BURST_LENGTHS        8'h0e

// ==========================================================
// timing
`define CLK_PERIOD_NS            40
`define CLK_KHZ                  25000
`define NOISE_NS                 50
`define NOISE_CYCLES             ((`NOISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROGRAM_TIME_MS          10
`define PROGRAM_CYCLES           (`PROGRAM_TIME_MS * `CLK_KHZ)

`endif

// ===== hdl/input_filter.v
// two-flop synchroniser and noise filter for each serial input.
// assumes inputs idle high and a 25 MHz sampling clock.
`timescale 1ns/1ps
`default_nettype none
`include "spd_consts.vh"

module input_filter #(
  parameter WIDTH = 6
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // raw and filtered levels
  input  wire [WIDTH-1:0] raw,
  output wire [WIDTH-1:0] clean
);

  localparam [31:0] LAST_FULL = `NOISE_CYCLES;
  localparam [1:0]  LAST      = LAST_FULL[1:0];

  // ==========================================================
  // per-bit synchroniser and filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg       sync1;
      reg       sync2;
      reg       level;
      reg [1:0] run;
      assign clean[i] = level;
      always @(posedge clk) begin
        if (!rst_n) begin
          sync1 <= 1'b1;
          sync2 <= 1'b1;
          level <= 1'b1;
          run   <= 2'h0;
        end else begin
          sync1 <= raw[i];
          sync2 <= sync1;
          if (sync2 == level) begin
            run <= 2'h0;
          end else if (run == LAST) begin
            level <= sync2;
            run   <= 2'h0;
          end else begin
            run <= run + 2'h1;
          end
        end
      end
    end
  endgenerate

endmodule // input_filter
`default_nettype wire

// ===== hdl/program_timer.v
// self-timed program cycle: busy for a fixed count after a start pulse.
// assumes start comes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "spd_consts.vh"

module program_timer #(
  parameter [17:0] CYCLES = `PROGRAM_CYCLES
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire start,
  output reg  busy
);

  reg [17:0] count;

  // ==========================================================
  // countdown
  always @(posedge clk) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      count <= 18'h0;
    end else if (start) begin
      busy  <= 1'b1;
      count <= CYCLES - 18'h1;
    end else if (busy) begin
      if (count == 18'h0) begin
        busy <= 1'b0;
      end else begin
        count <= count - 18'h1;
      end
    end
  end

endmodule // program_timer
`default_nettype wire

// ===== test/spd_slave_props.sv
// checker for the presence-detect slave: timing of the data-wire drive.
// assumes it is bound to the slave top and sees only its pins.
`timescale 1ns/1ps
`default_nettype none
module spd_slave_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial bus
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // straps and write control
  input wire logic STRAP_SELECT_BIT_HIGH,
  input wire logic STRAP_SELECT_BIT_MID,
  input wire logic STRAP_SELECT_BIT_LOW,
  input wire logic WRITE_CONTROL_INPUT
);
  // ========
  // clock rises during one unbroken drive
  logic       scl_d;
  logic [3:0] drive_bits;
  always @(posedge CLK) begin
    scl_d <= SCL;
    if (!SDA_OE) begin
      drive_bits <= 4'h0;
    end else if (SCL && !scl_d) begin
      drive_bits <= drive_bits + 4'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ========
  // properties
  AST_RESET_QUIET: assert property ($rose(RST_N) |-> !SDA_OE)
    else $error("data wire driven at reset release");
  AST_NEVER_HIGH: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data wire driven high");
  AST_RISE_IN_LOW: assert property ($rose(SDA_OE) |-> !SCL && !$past(SCL, 2))
    else $error("drive started outside clock low");
  AST_FALL_IN_LOW: assert property ($fell(SDA_OE) |-> !SCL && !$past(SCL, 2))
    else $error("drive ended outside clock low");
  AST_ACK_HOLDS: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
    else $error("drive shorter than eight cycles");
  AST_STEADY_HIGH: assert property ((SCL && $stable(SDA_IN)) [*8] |-> $stable(SDA_OE))
    else $error("drive changed while clock high");
  AST_STOP_QUIET: assert property (SCL && $rose(SDA_IN) |=> !SDA_OE [*6])
    else $error("drive after stop");
  AST_NINE_BITS: assert property (SDA_OE |-> drive_bits <= 4'h9)
    else $error("drive held past nine clocks");
  C_DRIVE: cover property ($rose(SDA_OE));
  C_NINE: cover property (drive_bits == 4'h9);
  C_STOP: cover property (SCL && $rose(SDA_IN));
endmodule // spd_slave_props
bind spd_slave spd_slave_props u_spd_slave_props (
  .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .STRAP_SELECT_BIT_HIGH(STRAP_SELECT_BIT_HIGH), .STRAP_SELECT_BIT_MID(STRAP_SELECT_BIT_MID),
  .STRAP_SELECT_BIT_LOW(STRAP_SELECT_BIT_LOW), .WRITE_CONTROL_INPUT(WRITE_CONTROL_INPUT));
`default_nettype wire

// ===== test/host_model.sv
// behavioural two-wire host: start, stop and nine-bit transfers.
// assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int HALF = 1320
) (
  // serial bus
  output logic     scl,
  output logic     sda_pull,
  input wire logic sda
);
  // ========
  // bus conditions
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    #(HALF / 2) sda_pull = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #(HALF) sda_pull = 1'b1;
    #(HALF) scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF / 2) sda_pull = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #(HALF) sda_pull = 1'b0;
    #(2 * HALF);
  endtask
  // eight bits out or in, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic nine,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] bits;
    bits = {tx, nine};
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 2) sda_pull = !bits[i];
      #(HALF / 2) scl = 1'b1;
      #(HALF) bits[i] = sda;
      scl = 1'b0;
    end
    rx = bits[8:1];
    ack = bits[0];
  endtask
endmodule // host_model
`default_nettype wire

// ===== test/spd_slave_tb.sv
// bench for the presence-detect slave: content, select, glitch, writes.
// assumes the host model and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, got, exp); end end
module spd_slave_tb;
  localparam int PROG = 200;
  int         n_errors = 0;
  int         n_tests  = 0;
  logic       CLK;
  logic       RST_N;
  logic       WRITE_CONTROL_INPUT;
  logic [2:0] strap;
  logic       host_scl;
  logic       host_pull;
  logic       glitch;
  logic       a;
  logic [7:0] rx;
  wire logic  SDA_OE;
  wire logic  SDA_OUT;
  wire logic  sda = !(host_pull || SDA_OE);
  wire logic  scl = host_scl ^ glitch;
  logic [7:0] rows [17] = '{8'h80, 8'h08, 8'h07, 8'h0d, 8'h0a, 8'h01, 8'h48, 8'h00,
    8'h04, 8'h50, 8'h70, 8'h02, 8'h82, 8'h08, 8'h08, 8'h01, 8'h0e};
  logic [3:0] codes [5] = '{4'ha, 4'h6, 4'h5, 4'ha, 4'ha};
  // ========
  // design and host
  spd_slave #(.PROGRAM_CYCLES(18'd200)) u_spd_slave (
    .CLK(CLK), .RST_N(RST_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .STRAP_SELECT_BIT_HIGH(strap[2]), .STRAP_SELECT_BIT_MID(strap[1]),
    .STRAP_SELECT_BIT_LOW(strap[0]), .WRITE_CONTROL_INPUT(WRITE_CONTROL_INPUT));
  host_model u_host_model (.scl(host_scl), .sda_pull(host_pull), .sda(sda));
  // ========
  // transfers
  task automatic sel(input logic [3:0] code, input logic [2:0] s, input logic rw,
                     input logic want);
    u_host_model.start();
    u_host_model.xfer({code, s, rw}, 1'b1, rx, a);
    `CHK(a, want)
  endtask
  task automatic point(input logic [3:0] code, input logic [7:0] ad);
    sel(code, 3'h5, 1'b0, 1'b0);
    u_host_model.xfer(ad, 1'b1, rx, a);
    `CHK(a, 1'b0)
    sel(code, 3'h5, 1'b1, 1'b0);
  endtask
  task automatic wr(input logic [7:0] ad, input int n, input logic busy);
    sel(4'ha, 3'h5, 1'b0, 1'b0);
    u_host_model.xfer(ad, 1'b1, rx, a);
    for (int k = 0; k < n; k++) begin
      u_host_model.xfer(8'hc0 + 8'(k), 1'b1, rx, a);
      `CHK(a, 1'b0)
    end
    u_host_model.stop();
    if (busy) begin
      sel(4'ha, 3'h5, 1'b0, 1'b1);
      u_host_model.stop();
    end
    repeat (PROG) @(negedge CLK);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ========
  // sequence
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    repeat (100000) @(posedge CLK);
    n_errors++;
    give_verdict();
  end
  initial begin
    RST_N = 1'b0;
    WRITE_CONTROL_INPUT = 1'b0;
    strap = 3'h5;
    glitch = 1'b0;
    repeat (5) @(negedge CLK);
    `CHK(SDA_OE, 1'b0)
    `CHK(SDA_OUT, 1'b0)
    RST_N = 1'b1;
    repeat (8) @(negedge CLK);
    $display("test reset done");
    point(4'ha, 8'h00);
    foreach (rows[i]) begin
      u_host_model.xfer(8'hff, i == 16, rx, a);
      `CHK(rx, rows[i])
    end
    repeat (10) @(negedge CLK);
    `CHK(SDA_OE, 1'b0)
    u_host_model.stop();
    sel(4'ha, 3'h5, 1'b1, 1'b0);
    u_host_model.xfer(8'hff, 1'b1, rx, a);
    `CHK(rx, 8'h00)
    u_host_model.stop();
    $display("test content done");
    for (int k = 0; k < 5; k++) begin
      @(negedge CLK);
      strap = (k == 4) ? 3'h2 : 3'h5;
      sel(codes[k], (k == 3) ? 3'h4 : strap, 1'b0, k == 2 || k == 3);
      u_host_model.stop();
    end
    @(negedge CLK);
    strap = 3'h5;
    point(4'h6, 8'h00);
    u_host_model.xfer(8'hff, 1'b1, rx, a);
    `CHK(rx, 8'h00)
    u_host_model.stop();
    $display("test select done");
    fork
      sel(4'ha, 3'h5, 1'b0, 1'b0);
      begin
        #4290;
        glitch = 1'b1;
        #40;
        glitch = 1'b0;
      end
    join
    u_host_model.stop();
    $display("test glitch done");
    wr(8'h35, 16, 1'b1);
    point(4'ha, 8'h30);
    for (int j = 0; j < 16; j++) begin
      u_host_model.xfer(8'hff, j == 15, rx, a);
      `CHK(rx, 8'hc0 + 8'((j + 11) % 16))
    end
    u_host_model.stop();
    @(negedge CLK);
    WRITE_CONTROL_INPUT = 1'b1;
    wr(8'h30, 1, 1'b0);
    @(negedge CLK);
    WRITE_CONTROL_INPUT = 1'b0;
    point(4'ha, 8'h30);
    u_host_model.xfer(8'hff, 1'b1, rx, a);
    `CHK(rx, 8'hcb)
    u_host_model.stop();
    $display("test writes done");
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (5) @(negedge CLK);
    `CHK(SDA_OE, 1'b0)
    RST_N = 1'b1;
    repeat (8) @(negedge CLK);
    point(4'ha, 8'h00);
    u_host_model.xfer(8'hff, 1'b1, rx, a);
    `CHK(rx, 8'h80)
    u_host_model.stop();
    $display("test second reset done");
    give_verdict();
  end
endmodule // spd_slave_tb
`default_nettype wire
